// ===== testbench.sv
// Self-checking bench for the unsigned 8x8 multiply datapath
`timescale 1ns/1ps
module testbench;
	import umul_pkg::*;
	logic        clk_in         = 1'b0;
	logic        nrst_in        = 1'b0;
	logic        ce_in          = 1'b1;
	logic        instr_valid_in = 1'b0;
	logic [15:0] instr_in       = 16'h0000;
	logic [7:0]  acc_in         = 8'h00;
	logic [7:0]  bank_reg       = 8'h00;
	logic [7:0]  rdata;
	logic        mem_rd_out;
	logic [11:0] mem_addr_out;
	logic        prod_we_out;
	logic [7:0]  prod_hi;
	logic [7:0]  prod_lo;
	int          n_checks       = 0;
	int          failures       = 0;
	logic [15:0] words [4]      = '{16'h0245, 16'h02b5, 16'h0345, 16'h03ff};
	logic [15:0] bad [4]        = '{16'h0e55, 16'h0c12, 16'h0400, 16'h0000};

	always #10 clk_in = ~clk_in;

	umul_top u_dut (
		.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in), .instr_valid_in(instr_valid_in),
		.instr_in(instr_in), .acc_in(acc_in), .bank_select_register_in(bank_reg), .mem_rdata_in(rdata),
		.mem_rd_out(mem_rd_out), .mem_addr_out(mem_addr_out), .prod_we_out(prod_we_out),
		.product_high_byte_out(prod_hi), .product_low_byte_out(prod_lo)
	);
	umul_mem_model u_mem (.rd_in(mem_rd_out), .addr_in(mem_addr_out), .rdata_out(rdata));

	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// One multiply; stall cycles hold ce low mid-flight, accumulator scrambled after issue
	task automatic mul(input logic [15:0] ins, input logic [7:0] a, input int stall);
		logic        rf;
		logic [11:0] ea;
		logic [7:0]  op;
		rf = (ins[15:9] == 7'h01);
		ea = ins[8] ? {bank_reg[3:0], ins[7:0]} : {{4{ins[7]}}, ins[7:0]};
		op = rf ? (ea[7:0] ^ {ea[11:8], ea[11:8]}) : ins[7:0];
		instr_in = ins;
		acc_in = a;
		instr_valid_in = 1'b1;
		@(negedge clk_in);
		instr_valid_in = 1'b0;
		acc_in = ~a;
		chk(16'(mem_rd_out), 16'(rf));
		if (rf) chk(16'(mem_addr_out), 16'(ea));
		repeat (stall) begin
			ce_in = 1'b0;
			@(negedge clk_in);
			chk(16'(prod_we_out), 16'h0000);
			chk(16'(mem_rd_out), 16'(rf));
		end
		ce_in = 1'b1;
		@(negedge clk_in);
		chk(16'(prod_we_out), 16'h0001);
		chk({prod_hi, prod_lo}, 16'(a) * 16'(op));
		@(negedge clk_in);
		chk(16'(prod_we_out), 16'h0000);
	endtask

	// Immediate then register form on consecutive cycles
	task automatic back_to_back();
		instr_in = 16'h0d10;
		acc_in = 8'h21;
		instr_valid_in = 1'b1;
		@(negedge clk_in);
		instr_in = 16'h0380;
		acc_in = 8'h9c;
		@(negedge clk_in);
		instr_valid_in = 1'b0;
		chk(16'(prod_we_out), 16'h0001);
		chk({prod_hi, prod_lo}, 16'h0210);
		chk(16'(mem_addr_out), {4'h0, bank_reg[3:0], 8'h80});
		@(negedge clk_in);
		chk(16'(prod_we_out), 16'h0001);
		chk({prod_hi, prod_lo}, 16'h9c * 16'(8'h80 ^ {2{bank_reg[3:0]}}));
	endtask

	// Words that are not multiplies leave every output alone
	task automatic ignored(input logic [15:0] ins);
		logic [15:0] keep;
		keep = {prod_hi, prod_lo};
		instr_in = ins;
		instr_valid_in = 1'b1;
		@(negedge clk_in);
		instr_valid_in = 1'b0;
		repeat (3) begin
			chk(16'({prod_we_out, mem_rd_out}), 16'h0000);
			chk({prod_hi, prod_lo}, keep);
			@(negedge clk_in);
		end
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		repeat (6) @(negedge clk_in);
		nrst_in = 1'b1;
		chk({prod_hi, prod_lo}, 16'h0000);
		mul(16'h0dc4, 8'he2, 0);
		mul(16'h0dff, 8'hff, 2);
		mul(16'h0d00, 8'h7b, 0);
		bank_reg = 8'h35;
		foreach (words[i]) mul(words[i], 8'hc4 - 8'(i), i % 2);
		back_to_back();
		foreach (bad[i]) ignored(bad[i]);
		conclude();
	end
endmodule // testbench

// ===== umul_array.sv
// Combinational unsigned 8x8 shift-and-add multiplier array
`timescale 1ns/1ps
module umul_array (
	umul_if.core mif
);
	// ************************************************************
	// Partial product chain
	// ************************************************************
	logic [15:0] psum [0:8];

	// Chain start at zero
	assign psum[0] = 16'h0000;

	// One adder row per multiplier bit; unsigned, so no sign extension rows
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_row
			assign psum[i+1] = psum[i] + (mif.opnd_b[i] ? (16'({8'h00, mif.opnd_a}) << i) : 16'h0000);
		end
	endgenerate

	// Full 16-bit result; cannot overflow for 8x8 unsigned operands
	assign mif.product = psum[8];
endmodule // umul_array

// ===== umul_if.sv
// Operand and product carrier between the datapath and its multiplier array
`timescale 1ns/1ps
interface umul_if;
	logic [7:0]  opnd_a;
	logic [7:0]  opnd_b;
	logic [15:0] product;

	modport src  (output opnd_a, output opnd_b, input product);
	modport core (input opnd_a, input opnd_b, output product);
endinterface

// ===== umul_mem_model.sv
// Behavioural data memory that answers the multiply datapath's reads
`timescale 1ns/1ps
module umul_mem_model (
	input  wire logic        rd_in,
	input  wire logic [11:0] addr_in,
	output logic      [7:0]  rdata_out
);
	logic [7:0] last_q = 8'h5a;

	// ************************************************************
	// Read port
	// ************************************************************
	// Outside a strobe the bus shows the inverse, so stale data never matches
	always_comb begin
		rdata_out = rd_in ? (addr_in[7:0] ^ {addr_in[11:8], addr_in[11:8]}) : ~last_q;
	end

	// Remember the last byte handed out; keyed on strobe and address so a repeated value is not missed
	always @(rd_in or addr_in) begin
		if (rd_in) last_q = addr_in[7:0] ^ {addr_in[11:8], addr_in[11:8]};
	end
endmodule // umul_mem_model

// ===== umul_pkg.sv
// Constants shared by the unsigned 8x8 multiply datapath
package umul_pkg;
	// ************************************************************
	// Instruction fields
	// ************************************************************
	localparam logic [7:0] OP_IMM_BYTE   = 8'h0d; // Upper byte of multiply_by_immediate
	localparam logic [6:0] OP_REG_BITS   = 7'h01; // Upper seven bits of multiply_by_register
	localparam int         OPC_BYTE_MSB  = 15;
	localparam int         OPC_BYTE_LSB  = 8;
	localparam int         OPC_REG_LSB   = 9;
	localparam int         SEL_BIT       = 8;     // Bank selector bit
	localparam int         LOW_BYTE_MSB  = 7;

	// ************************************************************
	// Data memory addressing
	// ************************************************************
	localparam logic [7:0] ACCESS_SPLIT  = 8'h80; // Offsets below map low, the split and above map high
	localparam logic [3:0] ACCESS_LO_BNK = 4'h0;
	localparam logic [3:0] ACCESS_HI_BNK = 4'hf;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0]  RST_BYTE  = 8'h00;
	localparam logic [11:0] RST_ADDR  = 12'h000;
	localparam logic [15:0] RST_PROD  = 16'h0000;
endpackage

// ===== umul_top.sv
// Unsigned 8x8 multiply datapath: decode, operand fetch, product register pair
`timescale 1ns/1ps
module umul_top
	import umul_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	input  wire logic        ce_in,
	input  wire logic        instr_valid_in,
	input  wire logic [15:0] instr_in,
	input  wire logic [7:0]  acc_in,
	input  wire logic [7:0]  bank_select_register_in,
	input  wire logic [7:0]  mem_rdata_in,
	output logic             mem_rd_out,
	output logic      [11:0] mem_addr_out,
	output logic             prod_we_out,
	output logic      [7:0]  product_high_byte_out,
	output logic      [7:0]  product_low_byte_out
);
	// ************************************************************
	// Decode
	// ************************************************************
	logic       take_imm;
	logic       take_reg;
	logic [7:0] low_byte;
	logic       bank_sel;

	// Stage zero decode of the incoming word
	assign take_imm = instr_valid_in && (instr_in[OPC_BYTE_MSB:OPC_BYTE_LSB] == OP_IMM_BYTE);
	assign take_reg = instr_valid_in && (instr_in[OPC_BYTE_MSB:OPC_REG_LSB] == OP_REG_BITS);
	assign low_byte = instr_in[LOW_BYTE_MSB:0];
	assign bank_sel = instr_in[SEL_BIT];

	// ************************************************************
	// Pipeline state
	// ************************************************************
	// Two-stage slot: issue registers the operands, the next enabled edge loads the product
	// Stages overlap, so a multiply may start on every enabled cycle
	// One cycle of latency gives the memory read a full cycle to settle
	logic        stg_vld_ff, nxt_stg_vld;
	logic        stg_reg_ff, nxt_stg_reg;
	logic [7:0]  opa_ff,     nxt_opa;
	logic [7:0]  imm_ff,     nxt_imm;
	logic        rd_ff,      nxt_rd;
	logic [11:0] addr_ff,    nxt_addr;
	logic        we_ff,      nxt_we;
	logic [15:0] prod_ff,    nxt_prod;

	umul_if mif ();

	// Second operand: literal, or the byte memory returns during the fetch slot
	assign mif.opnd_a = opa_ff;
	assign mif.opnd_b = stg_reg_ff ? mem_rdata_in : imm_ff;

	// Array is combinational: the memory byte must settle inside the strobe cycle
	umul_array u_array (
		.mif (mif.core)
	);

	// Next-state logic; everything holds while the clock enable is low
	always_comb begin
		nxt_stg_vld = stg_vld_ff;
		nxt_stg_reg = stg_reg_ff;
		nxt_opa     = opa_ff;
		nxt_imm     = imm_ff;
		nxt_rd      = rd_ff;
		nxt_addr    = addr_ff;
		nxt_we      = we_ff;
		nxt_prod    = prod_ff;
		if (ce_in) begin
			// Operand read: accumulator sampled at issue, never written back
			nxt_stg_vld = take_imm || take_reg;
			nxt_stg_reg = take_reg;
			nxt_rd      = take_reg; // Read strobe only; the block has no memory write path
			if (take_imm || take_reg) begin
				nxt_opa = acc_in;
				nxt_imm = low_byte;
			end
			if (take_reg) begin
				// Only four bank bits reach the 12-bit data space; upper bits are ignored
				if (bank_sel) begin
					nxt_addr = {bank_select_register_in[3:0], low_byte};
				end else if (low_byte < ACCESS_SPLIT) begin
					nxt_addr = {ACCESS_LO_BNK, low_byte};
				end else begin
					nxt_addr = {ACCESS_HI_BNK, low_byte};
				end
			end
			// Product write closes the instruction slot; no flag or zero detect exists
			nxt_we = stg_vld_ff;
			if (stg_vld_ff) begin
				nxt_prod = mif.product;
			end
		end
	end

	// Registers only
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			stg_vld_ff <= 1'b0;
			stg_reg_ff <= 1'b0;
			opa_ff     <= RST_BYTE;
			imm_ff     <= RST_BYTE;
			rd_ff      <= 1'b0;
			addr_ff    <= RST_ADDR;
			we_ff      <= 1'b0;
			prod_ff    <= RST_PROD;
		end else begin
			stg_vld_ff <= nxt_stg_vld;
			stg_reg_ff <= nxt_stg_reg;
			opa_ff     <= nxt_opa;
			imm_ff     <= nxt_imm;
			rd_ff      <= nxt_rd;
			addr_ff    <= nxt_addr;
			we_ff      <= nxt_we;
			prod_ff    <= nxt_prod;
		end
	end

	// Outputs straight from flops
	assign mem_rd_out            = rd_ff;
	assign mem_addr_out          = addr_ff;
	assign prod_we_out           = we_ff;
	assign product_high_byte_out = prod_ff[15:8];
	assign product_low_byte_out  = prod_ff[7:0];

	// ************************************************************
	// Assertions
	// ************************************************************
	// Words on the port that decode to neither multiply
	logic take_other;
	assign take_other = instr_valid_in && !take_imm && !take_reg;

	// Immediate product one enabled edge after issue
	a_imm_product: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(ce_in && take_imm) ##1 ce_in |=>
		({product_high_byte_out, product_low_byte_out} == 16'($past(acc_in, 2)) * 16'($past(instr_in[7:0], 2))))
		else $error("immediate product wrong");

	// Register product uses the byte returned during the strobe cycle
	a_reg_product: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(ce_in && take_reg) ##1 ce_in |=>
		({product_high_byte_out, product_low_byte_out} == 16'($past(acc_in, 2)) * 16'($past(mem_rdata_in, 1))))
		else $error("register product wrong");

	// Selector set: bank register picks the bank
	a_bank_addr: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(ce_in && take_reg && bank_sel) |=>
		(mem_rd_out && mem_addr_out == {$past(bank_select_register_in[3:0]), $past(instr_in[7:0])}))
		else $error("banked address wrong");

	// Selector clear: fixed access window, split at the offset midpoint
	a_access_addr: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(ce_in && take_reg && !bank_sel) |=>
		(mem_addr_out[7:0] == $past(instr_in[7:0]) &&
		 mem_addr_out[11:8] == (($past(instr_in[7:0]) < ACCESS_SPLIT) ? ACCESS_LO_BNK : ACCESS_HI_BNK)))
		else $error("access bank address wrong");

	// Every accepted multiply ends in a product write
	a_write_slot: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(ce_in && (take_imm || take_reg)) ##1 ce_in |=> prod_we_out)
		else $error("product write missing");

	// Product pair changes only on an enabled edge with a staged multiply
	a_prod_only_mul: assert property (@(posedge clk_in) disable iff (!nrst_in)
		$changed(prod_ff) |-> $past(stg_vld_ff) && $past(ce_in))
		else $error("product changed without multiply");

	// Memory is only ever read, and only for the register form
	a_rd_source: assert property (@(posedge clk_in) disable iff (!nrst_in)
		($rose(mem_rd_out)) |-> $past(take_reg) && $past(ce_in))
		else $error("memory read without register multiply");

	// Other opcodes never reach the product pair
	a_reject_other: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(ce_in && take_other) ##1 ce_in |=> !prod_we_out)
		else $error("non-multiply wrote product");

	// Clock enable low freezes the slot
	a_freeze_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!ce_in |=> $stable(prod_ff) && $stable(we_ff) && $stable(rd_ff))
		else $error("state moved while frozen");

	// Write pulse only follows a staged multiply
	a_we_source: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(prod_we_out && $past(ce_in)) |-> $past(stg_vld_ff))
		else $error("product write without staged multiply");

	// Read address moves only for a register multiply
	a_addr_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
		$changed(mem_addr_out) |-> $past(take_reg) && $past(ce_in))
		else $error("read address moved without register multiply");

	// Strobe drops when no register multiply issues
	a_rd_clear: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(ce_in && !take_reg) |=> !mem_rd_out)
		else $error("read strobe without register multiply");

	// Accumulator captured at issue, never fed back
	a_opnd_stage: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(ce_in && (take_imm || take_reg)) |=> (opa_ff == $past(acc_in)))
		else $error("accumulator operand not captured at issue");

	// ************************************************************
	// Coverage
	// ************************************************************
	// Both forms, both bank paths, overlap and a stalled slot
	c_imm: cover property (@(posedge clk_in) disable iff (!nrst_in) (ce_in && take_imm) ##1 ce_in ##1 prod_we_out);
	c_reg_banked: cover property (@(posedge clk_in) disable iff (!nrst_in) (ce_in && take_reg && bank_sel) ##1 ce_in);
	c_reg_access: cover property (@(posedge clk_in) disable iff (!nrst_in) (ce_in && take_reg && !bank_sel) ##1 ce_in);
	c_b2b: cover property (@(posedge clk_in) disable iff (!nrst_in) (ce_in && take_imm) ##1 (ce_in && take_reg));
	c_stall: cover property (@(posedge clk_in) disable iff (!nrst_in) (stg_vld_ff && !ce_in) ##1 ce_in ##1 prod_we_out);
endmodule // umul_top
